// ===== shared/asc_regs.svh
// Purpose: register offsets, field positions, reset values and frame counts of the serial control block
// Assumes: 32-bit APB, one aligned word per register
// Notes: included by name only
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ASC_OFF_CTRL_ONE   12'h000
`define ASC_OFF_CTRL_TWO   12'h004
`define ASC_OFF_CTRL_THREE 12'h008
`define ASC_OFF_DATA       12'h00C
`define ASC_OFF_STATUS     12'h010
`define ASC_OFF_BAUD       12'h014
// ----------------------------------------
// reset values
// ----------------------------------------
`define ASC_RST_CTRL_ONE   8'h00
`define ASC_RST_CTRL_TWO   8'h00
`define ASC_RST_BAUD       16'h0040
// ----------------------------------------
// third control register field positions
// ----------------------------------------
`define ASC_C3_RX_NINTH    7
`define ASC_C3_TX_NINTH    6
`define ASC_C3_OVF_EN      3
`define ASC_C3_NOISE_EN    2
`define ASC_C3_STOP_EN     1
`define ASC_C3_PAR_EN      0
// ----------------------------------------
// frame lengths in bit times and the lowest baud divisor
// ----------------------------------------
`define ASC_LEN_SHORT      4'hA
`define ASC_LEN_LONG       4'hB
`define ASC_BAUD_MIN       16'h0002
`endif

// ===== shared/asc_pkg.sv
// Purpose: types shared by the serial control block
// Assumes: field layouts of the first two control registers, msb first
// Notes: struct bit order equals register bit order
package asc_pkg;
  typedef struct packed {
    logic loopback_select;
    logic serial_module_on;
    logic tx_polarity_flip;
    logic nine_bit_chars;
    logic rx_resume_select;
    logic idle_count_after_stop;
    logic parity_on;
    logic odd_parity_select;
  } asc_ctrl_one_t;
  typedef struct packed {
    logic tx_empty_irq_on;
    logic tx_done_irq_on;
    logic rx_full_irq_on;
    logic rx_quiet_irq_on;
    logic tx_on;
    logic rx_on;
    logic rx_standby;
    logic break_send;
  } asc_ctrl_two_t;
  typedef struct packed {
    logic tx_buffer_empty_flag;
    logic tx_all_done_flag;
    logic rx_full_flag;
    logic rx_quiet_flag;
    logic rx_overflow_flag;
    logic noise_flag;
    logic stop_bit_bad_flag;
    logic parity_bad_flag;
  } asc_status_t;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } asc_rx_state_t;
endpackage

// ===== design/asc_serial_ctrl.sv
// Purpose: serial interface control logic with APB registers, transmitter and receiver
// Assumes: pins synchronous to pclk; one bit time is baud divisor cycles
// Notes: Function list below
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "asc_regs.svh"
module asc_serial_ctrl
  import asc_pkg::*;
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial pins
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  // interrupt requests
  output logic             tx_irq,
  output logic             rx_irq,
  output logic             err_irq
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic par_of(input logic [8:0] v, input logic odd);
    par_of = (^v) ^ odd;
  endfunction
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `ASC_OFF_CTRL_ONE) || (a == `ASC_OFF_CTRL_TWO) || (a == `ASC_OFF_CTRL_THREE) ||
             (a == `ASC_OFF_DATA) || (a == `ASC_OFF_STATUS) || (a == `ASC_OFF_BAUD);
  endfunction
  asc_ctrl_one_t c1_r;
  asc_ctrl_two_t c2_r;
  asc_status_t st_r;
  asc_rx_state_t rx_st_r;
  logic [3:0] c3_en_r;
  logic tx_ninth_r, rx_ninth_r, rx_quiet_armed_r, status_seen_r;
  logic [15:0] baud_r, tx_tmr_r, rx_tmr_r;
  logic [7:0] tx_data_r, rx_data_r;
  logic tx_data_full_r, pre_pend_r, brk_tail_r;
  logic [10:0] tx_sh_r;
  logic [3:0] tx_cnt_r, rx_bits_r, idle_cnt_r;
  logic [9:0] rx_sh_r;
  logic rx_prev_r;
  // ----------------------------------------
  // apb access
  // ----------------------------------------
  logic acc, wr, rd;
  logic [7:0] wb;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite && mapped(paddr);
  assign rd = acc && !pwrite && mapped(paddr);
  assign wb = pwdata[7:0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable && !pready;
      pslverr <= psel && !penable && !mapped(paddr);
      prdata <= 32'h00000000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `ASC_OFF_CTRL_ONE: prdata[7:0] <= c1_r;
          `ASC_OFF_CTRL_TWO: prdata[7:0] <= c2_r;
          `ASC_OFF_CTRL_THREE: prdata[7:0] <= {rx_ninth_r, tx_ninth_r, 2'b00, c3_en_r};
          `ASC_OFF_DATA: prdata[7:0] <= rx_data_r;
          `ASC_OFF_STATUS: prdata[7:0] <= st_r;
          `ASC_OFF_BAUD: prdata[15:0] <= baud_r;
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end
  // ----------------------------------------
  // baud and transmit timing
  // ----------------------------------------
  logic on, rx_en, tick, tx_load, tx_line;
  logic [3:0] flen;
  logic [10:0] dframe;
  assign on = c1_r.serial_module_on;
  assign rx_en = on && c2_r.rx_on;
  assign tick = on && (tx_tmr_r == 16'h0000);
  assign flen = c1_r.nine_bit_chars ? `ASC_LEN_LONG : `ASC_LEN_SHORT;
  assign tx_load = tick && (tx_cnt_r <= 4'h1);
  assign tx_line = (tx_cnt_r == 4'h0) ? 1'b1 : tx_sh_r[0];
  // data frame: start, data lsb first, msb position, stop
  always_comb begin
    if (c1_r.nine_bit_chars) begin
      dframe = {1'b1, c1_r.parity_on ? par_of({1'b0, tx_data_r}, c1_r.odd_parity_select) : tx_ninth_r,
                tx_data_r, 1'b0};
    end else begin
      dframe = {2'b11, c1_r.parity_on ? par_of({2'b00, tx_data_r[6:0]}, c1_r.odd_parity_select) : tx_data_r[7],
                tx_data_r[6:0], 1'b0};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_r <= `ASC_RST_BAUD;
      tx_tmr_r <= 16'h0000;
    end else begin
      if (wr && paddr == `ASC_OFF_BAUD) begin
        baud_r <= (pwdata[15:0] < `ASC_BAUD_MIN) ? `ASC_BAUD_MIN : pwdata[15:0];
      end
      if (!on || tick) begin
        tx_tmr_r <= baud_r - 16'h0001;
      end else begin
        tx_tmr_r <= tx_tmr_r - 16'h0001;
      end
    end
  end
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic wake_hit, idle_hit, rx_done, tx_on_rise;
  logic [9:0] new_sh;
  assign tx_on_rise = wr && paddr == `ASC_OFF_CTRL_TWO && wb[3] && !c2_r.tx_on;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_r <= `ASC_RST_CTRL_ONE;
      c2_r <= `ASC_RST_CTRL_TWO;
      c3_en_r <= 4'h0;
    end else begin
      if (wr && paddr == `ASC_OFF_CTRL_ONE) begin
        c1_r <= wb;
      end
      if (wr && paddr == `ASC_OFF_CTRL_TWO) begin
        c2_r <= wb;
      end else if (wake_hit) begin
        c2_r.rx_standby <= 1'b0;
      end
      if (wr && paddr == `ASC_OFF_CTRL_THREE) begin
        c3_en_r <= wb[3:0];
      end
    end
  end
  // ninth bits keep their value through reset
  always_ff @(posedge pclk) begin
    if (wr && paddr == `ASC_OFF_CTRL_THREE) begin
      tx_ninth_r <= wb[`ASC_C3_TX_NINTH];
    end
    if (rx_done && (!c2_r.rx_standby || wake_hit) && !st_r.rx_full_flag) begin
      rx_ninth_r <= new_sh[8];
    end
  end
  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_r <= 11'h7FF;
      tx_cnt_r <= 4'h0;
      tx_data_r <= 8'h00;
      tx_data_full_r <= 1'b0;
      pre_pend_r <= 1'b0;
      brk_tail_r <= 1'b0;
    end else if (!on) begin
      tx_sh_r <= 11'h7FF;
      tx_cnt_r <= 4'h0;
      tx_data_full_r <= 1'b0;
      pre_pend_r <= 1'b0;
      brk_tail_r <= 1'b0;
    end else begin
      if (wr && paddr == `ASC_OFF_DATA) begin
        tx_data_r <= wb;
        tx_data_full_r <= 1'b1;
      end
      if (tx_on_rise) begin
        pre_pend_r <= 1'b1;
      end
      if (tick && tx_cnt_r > 4'h1) begin
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_cnt_r <= tx_cnt_r - 4'h1;
      end else if (tx_load) begin
        if (c2_r.break_send && c2_r.tx_on) begin
          tx_sh_r <= 11'h000;
          tx_cnt_r <= flen;
          brk_tail_r <= 1'b1;
        end else if (brk_tail_r) begin
          tx_sh_r <= 11'h7FF;
          tx_cnt_r <= 4'h1;
          brk_tail_r <= 1'b0;
        end else if (pre_pend_r && c2_r.tx_on) begin
          tx_sh_r <= 11'h7FF;
          tx_cnt_r <= flen;
          pre_pend_r <= tx_on_rise;
        end else if (tx_data_full_r && c2_r.tx_on) begin
          tx_sh_r <= dframe;
          tx_cnt_r <= flen;
          tx_data_full_r <= wr && paddr == `ASC_OFF_DATA;
        end else begin
          tx_cnt_r <= 4'h0;
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_pin <= 1'b1;
    end else begin
      serial_out_pin <= tx_line ^ c1_r.tx_polarity_flip;
    end
  end
  // ----------------------------------------
  // receiver
  // ----------------------------------------
  logic rx_in, rx_sample, noise_hit, msb_mark;
  logic [7:0] rx_byte;
  logic [8:0] par_vec;
  assign rx_in = c1_r.loopback_select ? serial_out_pin : serial_in_pin;
  assign rx_sample = (rx_tmr_r == 16'h0000);
  assign new_sh = {rx_in, rx_sh_r[9:1]};
  assign rx_done = rx_en && rx_st_r == RX_DATA && rx_sample && rx_bits_r == flen - 4'h2;
  assign msb_mark = new_sh[8];
  assign rx_byte = c1_r.nine_bit_chars ? new_sh[7:0] : new_sh[8:1];
  assign par_vec = c1_r.nine_bit_chars ? new_sh[8:0] : {1'b0, new_sh[8:1]};
  assign noise_hit = rx_en && rx_st_r != RX_IDLE && rx_sample && (rx_in != rx_prev_r);
  assign idle_hit = rx_en && rx_sample && rx_in && (idle_cnt_r == flen - 4'h1);
  assign wake_hit = c2_r.rx_standby && (c1_r.rx_resume_select ? (rx_done && msb_mark) : idle_hit);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_r <= RX_IDLE;
      rx_tmr_r <= 16'h0000;
      rx_bits_r <= 4'h0;
      rx_sh_r <= 10'h000;
      rx_prev_r <= 1'b1;
      idle_cnt_r <= 4'h0;
    end else begin
      rx_prev_r <= rx_in;
      if (!rx_en) begin
        rx_st_r <= RX_IDLE;
        rx_tmr_r <= baud_r - 16'h0001;
        idle_cnt_r <= 4'h0;
      end else begin
        rx_tmr_r <= rx_sample ? baud_r - 16'h0001 : rx_tmr_r - 16'h0001;
        if (idle_hit) begin
          idle_cnt_r <= 4'hF;
        end else if (rx_sample && idle_cnt_r != 4'hF && (rx_st_r == RX_IDLE ||
                     (rx_st_r == RX_DATA && !c1_r.idle_count_after_stop))) begin
          idle_cnt_r <= rx_in ? idle_cnt_r + 4'h1 : 4'h0;
        end
        case (rx_st_r)
          RX_IDLE: begin
            if (rx_prev_r && !rx_in) begin
              rx_st_r <= RX_START;
              rx_tmr_r <= {1'b0, baud_r[15:1]};
              idle_cnt_r <= 4'h0;
            end
          end
          RX_START: begin
            if (rx_sample) begin
              rx_st_r <= rx_in ? RX_IDLE : RX_DATA;
              rx_bits_r <= 4'h0;
            end
          end
          RX_DATA: begin
            if (rx_sample) begin
              rx_sh_r <= new_sh;
              rx_bits_r <= rx_bits_r + 4'h1;
              if (rx_done) begin
                rx_st_r <= RX_IDLE;
              end
            end
          end
          default: rx_st_r <= RX_IDLE;
        endcase
      end
    end
  end
  // ----------------------------------------
  // status flags, hardware set wins over clear
  // ----------------------------------------
  logic deliver, clr_rx, tx_busy;
  assign deliver = rx_done && (!c2_r.rx_standby || wake_hit);
  assign clr_rx = rd && paddr == `ASC_OFF_DATA && status_seen_r;
  assign tx_busy = tx_cnt_r != 4'h0 || pre_pend_r || brk_tail_r || c2_r.break_send || tx_data_full_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= 8'hC0;
      rx_data_r <= 8'h00;
      rx_quiet_armed_r <= 1'b0;
      status_seen_r <= 1'b0;
    end else begin
      if (rd && paddr == `ASC_OFF_STATUS) begin
        status_seen_r <= 1'b1;
      end else if (clr_rx) begin
        status_seen_r <= 1'b0;
      end
      st_r.tx_buffer_empty_flag <= !on || !tx_data_full_r || (tx_load && !tx_busy) ? 1'b1 :
                                   st_r.tx_buffer_empty_flag && !(wr && paddr == `ASC_OFF_DATA);
      if (on && tx_data_full_r) begin
        st_r.tx_buffer_empty_flag <= 1'b0;
      end
      st_r.tx_all_done_flag <= !on || !tx_busy;
      if (clr_rx) begin
        st_r[5:0] <= 6'h00;
      end
      if (deliver) begin
        if (st_r.rx_full_flag && !clr_rx) begin
          st_r.rx_overflow_flag <= 1'b1;
        end else begin
          rx_data_r <= rx_byte;
          st_r.rx_full_flag <= 1'b1;
          st_r.stop_bit_bad_flag <= !new_sh[9];
          st_r.parity_bad_flag <= c1_r.parity_on && par_of(par_vec, c1_r.odd_parity_select);
          rx_quiet_armed_r <= 1'b1;
        end
      end
      if (noise_hit && !c2_r.rx_standby) begin
        st_r.noise_flag <= 1'b1;
      end
      if (idle_hit && !c2_r.rx_standby && rx_quiet_armed_r) begin
        st_r.rx_quiet_flag <= 1'b1;
        rx_quiet_armed_r <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // request lines
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
      err_irq <= 1'b0;
    end else begin
      tx_irq <= on && ((c2_r.tx_empty_irq_on && st_r.tx_buffer_empty_flag) ||
                       (c2_r.tx_done_irq_on && st_r.tx_all_done_flag));
      rx_irq <= on && !c2_r.rx_standby && ((c2_r.rx_full_irq_on && st_r.rx_full_flag) ||
                                           (c2_r.rx_quiet_irq_on && st_r.rx_quiet_flag));
      err_irq <= on && |(c3_en_r & st_r[3:0]);
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pin_polarity: assert property (##1 serial_out_pin == ($past(tx_line) ^ $past(c1_r.tx_polarity_flip)))
    else $error("transmit pin polarity wrong");
  a_off_tx_flags: assert property (!on |=> st_r.tx_buffer_empty_flag && st_r.tx_all_done_flag)
    else $error("tx flags not forced while off");
  a_off_no_req: assert property (!on |=> !tx_irq && !rx_irq && !err_irq)
    else $error("request while module off");
  a_standby_quiet: assert property (c2_r.rx_standby |=> !rx_irq)
    else $error("receiver request in standby");
  a_break_frame: assert property (tx_load && on && c2_r.break_send && c2_r.tx_on |=> tx_sh_r == 11'h000 && tx_cnt_r == flen)
    else $error("break frame not loaded");
  a_preamble_len: assert property (tx_load && on && c2_r.tx_on && !c2_r.break_send && !brk_tail_r && pre_pend_r
                                   |=> tx_sh_r == 11'h7FF && tx_cnt_r == $past(flen))
    else $error("preamble frame wrong");
  a_tx_parity: assert property (tx_load && on && c2_r.tx_on && !c2_r.break_send && !brk_tail_r && !pre_pend_r
                                && tx_data_full_r && c1_r.parity_on
                                |=> (^(c1_r.nine_bit_chars ? tx_sh_r[9:1] : {1'b0, tx_sh_r[8:1]}))
                                    == $past(c1_r.odd_parity_select))
    else $error("transmit parity wrong");
  a_mark_wake: assert property (rx_done && c2_r.rx_standby && c1_r.rx_resume_select && msb_mark && !st_r.rx_full_flag
                                |=> st_r.rx_full_flag && !c2_r.rx_standby)
    else $error("msb mark wake incomplete");
  a_idle_wake: assert property (idle_hit && c2_r.rx_standby && !c1_r.rx_resume_select && !st_r.rx_quiet_flag
                                |=> !c2_r.rx_standby && !st_r.rx_quiet_flag)
    else $error("idle wake wrong");
  a_err_gate: assert property (on && c3_en_r == 4'h0 |=> !err_irq)
    else $error("error request without enable");
  c_break_sent: cover property (tx_load && c2_r.break_send ##1 tx_sh_r == 11'h000);
  c_frame_rx: cover property (rx_done && !c2_r.rx_standby);
  c_mark_wake: cover property (wake_hit && c1_r.rx_resume_select);
  c_loop_rx: cover property (rx_done && c1_r.loopback_select);
endmodule

// ===== verif/asc_remote.sv
// Purpose: remote serial device facing the block's pins
// Assumes: bit time is DIV clock cycles, lsb first
// Notes: line idles high between frames
`timescale 1ns/1ps
module asc_remote #(
  parameter int DIV = 4
) (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic line_in,
  output logic line_out
);
  // ----------------------------------------
  // transmitter and receiver
  // ----------------------------------------
  initial line_out = 1'b1;
  // start, nb bits lsb first, stop
  task automatic send(input logic [8:0] d, input int nb);
    line_out <= 1'b0;
    repeat (DIV) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      line_out <= d[i];
      repeat (DIV) @(posedge clk);
    end
    line_out <= 1'b1;
    repeat (DIV) @(posedge clk);
  endtask
  // wait for a start edge, then sample nb bits mid-bit
  task automatic recv(input logic inv, input int nb, output logic [10:0] f, output int w);
    f = '0;
    w = 0;
    while ((line_in ^ inv) !== 1'b0 && w < 2000) begin
      @(posedge clk);
      w++;
    end
    repeat (DIV / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      f[i] = line_in ^ inv;
      repeat (DIV) @(posedge clk);
    end
  endtask
endmodule

// ===== verif/tb.sv
// Purpose: self-checking bench for the serial control block
// Assumes: bit time of 4 cycles
// Notes: remote model drives the receive pin
`timescale 1ns/1ps
module tb;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, se, sin, sout, tx_irq, rx_irq, err_irq;
  int fail_count = 0;
  int n_tests = 0;
  asc_serial_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_in_pin(sin), .serial_out_pin(sout), .tx_irq(tx_irq), .rx_irq(rx_irq), .err_irq(err_irq));
  asc_remote #(.DIV(4)) u_rem (.clk(pclk), .line_in(sout), .line_out(sin));
  initial begin
    forever #50 pclk = ~pclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize();
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      summarize();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic fr(input string nm, input logic inv, input int nb, input logic [10:0] exp, output int w);
    logic [10:0] f;
    u_rem.recv(inv, nb, f, w);
    if (w >= 2000) begin
      fail_count++;
      summarize();
    end
    chk(nm, f, exp);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdc("ctrl_one", 12'h000, 32'h0);
    rdc("ctrl_two", 12'h004, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk("ctrl_three_en", rd & 32'hF, 32'h0);
    rdc("status", 12'h010, 32'hC0);
    rdc("unmapped", 12'h040, 32'h0);
    chk("slverr", se, 1'b1);
    chk("pin_idle", sout, 1'b1);
  endtask
  task automatic t_tx();
    int w;
    wr(12'h014, 32'h4);
    wr(12'h000, 32'h40);
    wr(12'h004, 32'h48);
    wr(12'h00C, 32'hA5);
    fr("frame8", 1'b0, 10, {2'b01, 8'hA5, 1'b0}, w);
    chk("preamble", w >= 30 && w <= 50, 1'b1);
    repeat (4) @(posedge pclk);
    chk("tx_done_irq", tx_irq, 1'b1);
    wr(12'h000, 32'h50);
    wr(12'h008, 32'h40);
    wr(12'h00C, 32'h5A);
    fr("frame9", 1'b0, 11, {2'b11, 8'h5A, 1'b0}, w);
    for (int o = 0; o < 2; o++) begin
      wr(12'h000, 32'h42 | 32'(o));
      wr(12'h00C, 32'h03);
      fr("parity", 1'b0, 10, {2'b01, 1'(o), 7'h03, 1'b0}, w);
    end
  endtask
  task automatic t_rx();
    wr(12'h000, 32'h40);
    wr(12'h004, 32'h24);
    wr(12'h008, 32'h02);
    u_rem.send(9'h0A5, 8);
    repeat (4) @(posedge pclk);
    chk("rx_irq", rx_irq, 1'b1);
    rdc("rx_status", 12'h010, 32'hE0);
    rdc("rx_data", 12'h00C, 32'hA5);
    apb(1'b0, 12'h008, 32'h0);
    chk("rx_ninth", rd[7], 1'b1);
    chk("rx_irq_clr", rx_irq, 1'b0);
    // stop position held low
    u_rem.send(9'h0FF, 9);
    repeat (4) @(posedge pclk);
    chk("err_irq", err_irq, 1'b1);
    wr(12'h008, 32'h0);
    repeat (2) @(posedge pclk);
    chk("err_masked", err_irq, 1'b0);
    wr(12'h004, 32'h00);
    rdc("flags_kept", 12'h010, 32'hE2);
    rdc("rx_data2", 12'h00C, 32'hFF);
  endtask
  task automatic t_wake();
    wr(12'h000, 32'h48);
    wr(12'h004, 32'h26);
    u_rem.send(9'h011, 8);
    repeat (4) @(posedge pclk);
    rdc("standby_held", 12'h004, 32'h26);
    chk("rx_irq_standby", rx_irq, 1'b0);
    u_rem.send(9'h091, 8);
    repeat (4) @(posedge pclk);
    rdc("woken", 12'h004, 32'h24);
    chk("wake_full", rx_irq, 1'b1);
    // idle-line wake: the character is swallowed, the idle after it wakes
    apb(1'b0, 12'h010, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    wr(12'h000, 32'h40);
    wr(12'h004, 32'h26);
    u_rem.send(9'h055, 8);
    repeat (60) @(posedge pclk);
    rdc("idle_woken", 12'h004, 32'h24);
    rdc("idle_wake_flags", 12'h010, 32'hC0);
  endtask
  task automatic t_loop();
    apb(1'b0, 12'h010, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    wr(12'h000, 32'hC0);
    wr(12'h004, 32'h0C);
    wr(12'h00C, 32'h3C);
    // pin traffic must not reach the receiver
    u_rem.send(9'h011, 8);
    repeat (80) @(posedge pclk);
    rdc("loop_data", 12'h00C, 32'h3C);
  endtask
  task automatic t_brk();
    int w;
    wr(12'h000, 32'h40);
    wr(12'h004, 32'h09);
    fr("break", 1'b0, 10, 11'h0, w);
    chk("break_held", sout, 1'b0);
    wr(12'h004, 32'h08);
    repeat (50) @(posedge pclk);
    chk("break_tail", sout, 1'b1);
  endtask
  task automatic t_off();
    wr(12'h004, 32'h88);
    repeat (4) @(posedge pclk);
    chk("tx_empty_irq", tx_irq, 1'b1);
    wr(12'h000, 32'h60);
    repeat (2) @(posedge pclk);
    chk("inverted_idle", sout, 1'b0);
    wr(12'h000, 32'h00);
    repeat (2) @(posedge pclk);
    chk("off_irq", tx_irq, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    chk("off_status", rd & 32'hC0, 32'hC0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_wake();
    t_loop();
    t_brk();
    t_off();
    summarize();
  end
endmodule
